// ==== irq_event_pkg.sv ====
`default_nettype none
package irq_event_pkg;
	// ==========================================
	// Register offsets and layout
	localparam logic [7:0] OFS_EVENT_SET = 8'h80;
	localparam logic [7:0] OFS_EVENT_CLR = 8'h84;
	localparam int BIT_LOST_CYCLE   = 22;
	localparam int BIT_SECONDS      = 21;
	localparam int BIT_NEW_CYCLE    = 20;
	localparam int BIT_PHY_IRQ      = 19;
	localparam int BIT_BUS_RESET    = 17;
	localparam int BIT_SELF_ID      = 16;
	localparam int BIT_LOCK_ERR     = 9;
	localparam int BIT_POSTED_ERR   = 8;
	localparam int BIT_ISO_RX       = 7;
	localparam int BIT_ISO_TX       = 6;
	localparam int BIT_RESP_PKT     = 5;
	localparam int BIT_REQ_PKT      = 4;
	localparam int BIT_RX_RESP_DONE = 3;
	localparam int BIT_RX_REQ_DONE  = 2;
	localparam int BIT_TX_RESP_DONE = 1;
	localparam int BIT_TX_REQ_DONE  = 0;
	// Top bit of the seven-bit seconds count
	localparam int SECONDS_WATCH    = 6;
	// Latched (set/clear) bits of the lower event word
	localparam logic [22:0] LATCH_MASK = 23'h7B033F;
	localparam logic [22:0] EVENT_RESET = 23'h000000;
	localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

	// ==========================================
	// Hardware event strobes, one cycle each
	typedef struct packed {
		logic lock_resp_err;
		logic posted_wr_err;
		logic phy_status_irq;
		logic phy_bus_reset;
		logic self_id_stream_end;
		logic resp_pkt_stored;
		logic req_pkt_stored;
		logic rx_resp_cmd_done;
		logic rx_req_cmd_done;
		logic tx_resp_cmd_done;
		logic tx_req_cmd_done;
		logic subaction_gap;
		logic arb_reset_gap;
		logic cycle_start_seen;
	} hw_events_t;

	// Host register access
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} host_req_t;
endpackage
`default_nettype wire

// ==== serial_bus_interrupt_event_bits.sv ====
`default_nettype none
// Contract
// RULE_01: Lost cycle: two new cycles without cycle_start
// RULE_02: Predict lost cycle from gaps
// RULE_03: Seconds bit seven change sets rollover
// RULE_04: Cycle count LSB toggle sets new_cycle
// RULE_05: Physical-layer status interrupt sets flag
// RULE_06: Reserved bits read zero
// RULE_07: Bus reset entry sets flag
// RULE_08: Self-id stream end sets done
// RULE_09: Bus reset clears self-id done
// RULE_10: Unacknowledged lock response sets error
// RULE_11: Host error on posted write sets error
// RULE_12: Iso receive summary, unlatched OR
// RULE_13: Iso transmit summary, unlatched OR
// RULE_14: Response packet stored sets flag
// RULE_15: Request packet stored sets flag
// RULE_16: Rx response descriptor completion sets flag
// RULE_17: Rx request descriptor completion sets flag
// RULE_18: Tx response command completion sets flag
// RULE_19: Tx request command completion sets flag
// RULE_20: Set and clear addresses; clear read masked
// RULE_21: Write one sets or clears; zero ignored
// RULE_22: Hardware set beats software clear
module serial_bus_interrupt_event_bits
	import irq_event_pkg::*;
#(
	parameter int ISO_CTX = 8
)(
	// Clock and reset
	input  wire logic               mclk_in,
	input  wire logic               rst_n_in,
	// Host register access
	input  wire host_req_t          host_req_in,
	output logic [31:0]             rdata_out,
	output logic                    rvalid_out,
	// Cycle timer state
	input  wire logic [6:0]         cycle_seconds_in,
	input  wire logic               cycle_count_lsb_in,
	// Block-internal event strobes
	input  wire hw_events_t         events_in,
	// Neighbour registers
	input  wire logic [22:0]        int_mask_in,
	input  wire logic [ISO_CTX-1:0] iso_rx_event_in,
	input  wire logic [ISO_CTX-1:0] iso_rx_mask_in,
	input  wire logic [ISO_CTX-1:0] iso_tx_event_in,
	input  wire logic [ISO_CTX-1:0] iso_tx_mask_in,
	// Flag state
	output logic [22:0]             event_flags_out
);

	// ==========================================
	// State
	logic [22:0] event_reg,    event_next;
	logic        sec_bit_reg,  sec_bit_next;
	logic        lsb_reg,      lsb_next;
	logic        armed_reg,    armed_next;
	logic        seen_reg,     seen_next;
	logic        gap_done_reg, gap_done_next;
	logic        prime_reg,    prime_next;
	logic [31:0] rdata_reg,    rdata_next;
	logic        rvalid_reg,   rvalid_next;

	// Set and clear requests for this edge
	logic [22:0] hw_set;
	logic [22:0] sw_set;
	logic [22:0] sw_clr;
	// Read view with the live summary bits merged in
	logic [22:0] live;
	// Timer and lost-cycle strobes
	logic        new_cycle;
	logic        sec_change;
	logic        lost;
	// Unlatched summaries of the context registers
	logic        iso_rx_sum;
	logic        iso_tx_sum;
	// Decoded host strobes
	logic        wr_set_hit;
	logic        wr_clr_hit;
	logic        rd_set_hit;
	logic        rd_clr_hit;

	// ==========================================
	// Helper functions
	// True when a strobe targets the given offset
	function automatic logic addr_hit(
		input logic       strobe,
		input logic [7:0] addr,
		input logic [7:0] offset
	);
		return strobe && (addr == offset);
	endfunction

	// Latched bits a one-write may touch
	function automatic logic [22:0] write_bits(
		input logic [31:0] wdata
	);
		// Summary and reserved bits never take a write
		return wdata[22:0] & LATCH_MASK;
	endfunction

	// Any context both flagged and enabled
	function automatic logic any_masked(
		input logic [ISO_CTX-1:0] event_bits,
		input logic [ISO_CTX-1:0] mask_bits
	);
		return |(event_bits & mask_bits);
	endfunction

	// Zero-extend the lower event word to the bus width
	function automatic logic [31:0] widen(
		input logic [22:0] bits
	);
		return {9'h000, bits};
	endfunction

	// ==========================================
	// Event detection
	// Each flag strobe on events_in is one cycle wide and lands in
	// its flag on the next edge (self-id end only without a bus reset); the timer bits become strobes
	// here by comparing them with the tracked copies
	always_comb
	begin
		new_cycle = prime_reg && (cycle_count_lsb_in != lsb_reg); // RULE_04
		sec_change = prime_reg && (cycle_seconds_in[SECONDS_WATCH] != sec_bit_reg); // RULE_03
		iso_rx_sum = any_masked(iso_rx_event_in, iso_rx_mask_in); // RULE_12
		iso_tx_sum = any_masked(iso_tx_event_in, iso_tx_mask_in); // RULE_13
		lost = 1'b0;
		// Second boundary with no start in between
		if (new_cycle && armed_reg && !seen_reg && !events_in.cycle_start_seen)
			lost = 1'b1; // RULE_01
		// Prediction lets software react before the next boundary;
		// a start that arrives late still leaves the flag set
		// Second subaction gap after boundary with no start yet
		if (armed_reg && !seen_reg && gap_done_reg && events_in.subaction_gap)
			lost = 1'b1; // RULE_02
		// Arbitration reset gap before any start
		if (armed_reg && !seen_reg && events_in.arb_reset_gap)
			lost = 1'b1; // RULE_02
		// Collect all hardware set requests by flag position
		hw_set = '0;
		hw_set[BIT_LOST_CYCLE]   = lost;
		hw_set[BIT_SECONDS]      = sec_change; // RULE_03
		hw_set[BIT_NEW_CYCLE]    = new_cycle; // RULE_04
		hw_set[BIT_PHY_IRQ]      = events_in.phy_status_irq; // RULE_05
		hw_set[BIT_BUS_RESET]    = events_in.phy_bus_reset; // RULE_07
		hw_set[BIT_SELF_ID]      = events_in.self_id_stream_end && !events_in.phy_bus_reset; // RULE_08
		hw_set[BIT_LOCK_ERR]     = events_in.lock_resp_err; // RULE_10
		hw_set[BIT_POSTED_ERR]   = events_in.posted_wr_err; // RULE_11
		hw_set[BIT_RESP_PKT]     = events_in.resp_pkt_stored; // RULE_14
		hw_set[BIT_REQ_PKT]      = events_in.req_pkt_stored; // RULE_15
		hw_set[BIT_RX_RESP_DONE] = events_in.rx_resp_cmd_done; // RULE_16
		hw_set[BIT_RX_REQ_DONE]  = events_in.rx_req_cmd_done; // RULE_17
		hw_set[BIT_TX_RESP_DONE] = events_in.tx_resp_cmd_done; // RULE_18
		hw_set[BIT_TX_REQ_DONE]  = events_in.tx_req_cmd_done; // RULE_19
	end

	// ==========================================
	// Timer trackers
	// Keep the last timer bits so a change reads as an event;
	// prime stays low for the first cycle out of reset so the
	// trackers load before any compare, avoiding a false event
	always_comb
	begin
		prime_next   = 1'b1;
		sec_bit_next = cycle_seconds_in[SECONDS_WATCH];
		lsb_next     = cycle_count_lsb_in;
	end

	// Timer tracker registers
	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in)
		begin
			prime_reg   <= 1'b0;
			sec_bit_reg <= 1'b0;
			lsb_reg     <= 1'b0;
		end
		else
		begin
			prime_reg   <= prime_next;
			sec_bit_reg <= sec_bit_next;
			lsb_reg     <= lsb_next;
		end
	end

	// ==========================================
	// Lost-cycle bookkeeping
	// armed: a boundary has passed since reset and since any predicted loss
	// seen: a cycle start arrived since the last boundary
	// gap_done: the first subaction gap of this cycle passed
	// A start on the boundary edge also opens the new cycle
	always_comb
	begin
		armed_next    = armed_reg;
		seen_next     = seen_reg || events_in.cycle_start_seen;
		gap_done_next = gap_done_reg;
		if (new_cycle)
		begin
			armed_next    = 1'b1;
			seen_next     = events_in.cycle_start_seen;
			gap_done_next = 1'b0;
		end
		else if (events_in.subaction_gap)
			gap_done_next = 1'b1;
		// Only flag one predicted loss per cycle
		if (lost && !new_cycle)
			armed_next = 1'b0;
	end

	// Lost-cycle registers
	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in)
		begin
			armed_reg    <= 1'b0;
			seen_reg     <= 1'b0;
			gap_done_reg <= 1'b0;
		end
		else
		begin
			armed_reg    <= armed_next;
			seen_reg     <= seen_next;
			gap_done_reg <= gap_done_next;
		end
	end

	// ==========================================
	// Host access decode
	// One strobe per access; any other offset is ignored
	always_comb
	begin
		wr_set_hit = addr_hit(host_req_in.wr, host_req_in.addr, OFS_EVENT_SET); // RULE_20
		wr_clr_hit = addr_hit(host_req_in.wr, host_req_in.addr, OFS_EVENT_CLR); // RULE_20
		rd_set_hit = addr_hit(host_req_in.rd, host_req_in.addr, OFS_EVENT_SET); // RULE_20
		rd_clr_hit = addr_hit(host_req_in.rd, host_req_in.addr, OFS_EVENT_CLR); // RULE_20
		sw_set = '0;
		sw_clr = '0;
		if (wr_set_hit)
			sw_set = write_bits(host_req_in.wdata); // RULE_21
		if (wr_clr_hit)
			sw_clr = write_bits(host_req_in.wdata); // RULE_21
	end

	// ==========================================
	// Flag update
	// Hardware sets are merged after the clear so an event
	// landing together with a clear write is never lost
	always_comb
	begin
		event_next = ((event_reg & ~sw_clr) | sw_set | hw_set) & LATCH_MASK; // RULE_22
		// Bus reset entry wipes a stale self-id result
		if (events_in.phy_bus_reset)
			event_next[BIT_SELF_ID] = 1'b0; // RULE_09
	end

	// Flag register
	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in)
			event_reg <= EVENT_RESET;
		else
			event_reg <= event_next;
	end

	// ==========================================
	// Read port
	// Summary bits are live, taken on the read edge
	always_comb
	begin
		live = event_reg;
		live[BIT_ISO_RX] = iso_rx_sum; // RULE_12
		live[BIT_ISO_TX] = iso_tx_sum; // RULE_13
		// Valid pulses for any read, mapped or not
		rvalid_next = host_req_in.rd;
		// Unmapped offsets and reserved bits read as zero
		rdata_next  = '0; // RULE_06
		if (rd_set_hit)
			rdata_next = widen(live); // RULE_20
		else if (rd_clr_hit)
			rdata_next = widen(live & int_mask_in); // RULE_20
	end

	// Read data registers
	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in)
		begin
			rdata_reg  <= RDATA_RESET;
			rvalid_reg <= 1'b0;
		end
		else
		begin
			rdata_reg  <= rdata_next;
			rvalid_reg <= rvalid_next;
		end
	end

	// ==========================================
	// Outputs
	// Straight from flip-flops; summaries are never latched,
	// so bits 7 and 6 of the flag word stay low
	assign rdata_out       = rdata_reg;
	assign rvalid_out      = rvalid_reg;
	assign event_flags_out = event_reg;

endmodule
`default_nettype wire

// ==== serial_bus_interrupt_event_bits_assertions.sv ====
`default_nettype none
module serial_bus_interrupt_event_bits_assertions
	import irq_event_pkg::*;
(
	// Watched ports
	input wire logic		mclk_in,
	input wire logic		rst_n_in,
	input wire host_req_t	host_req_in,
	input wire logic [31:0]	rdata_out,
	input wire logic		rvalid_out,
	input wire logic [6:0]	cycle_seconds_in,
	input wire logic		cycle_count_lsb_in,
	input wire hw_events_t	events_in,
	input wire logic [22:0]	int_mask_in,
	input wire logic [22:0]	event_flags_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);
	// ==========================================
	// Decoded host accesses
	wire logic rd_clr = host_req_in.rd && host_req_in.addr == OFS_EVENT_CLR;
	wire logic wr_clr = host_req_in.wr && host_req_in.addr == OFS_EVENT_CLR;
	wire logic wr_set = host_req_in.wr && host_req_in.addr == OFS_EVENT_SET;
	// ==========================================
	// Flag and read-back checks
	chk_bus_reset: assert property (
		events_in.phy_bus_reset |=> event_flags_out[17] && !event_flags_out[16])
		else $error("bus reset flags wrong");
	chk_rsvd_zero: assert property (
		!(event_flags_out & ~LATCH_MASK) &&
		!(rvalid_out && |{rdata_out[31:23], rdata_out[18], rdata_out[15:10]}))
		else $error("reserved bit set");
	chk_read_pulse: assert property (host_req_in.rd |=> rvalid_out)
		else $error("no read valid");
	chk_clr_masked: assert property (
		rd_clr |=> !(rdata_out[22:0] & ~$past(int_mask_in)))
		else $error("clear read not masked");
	chk_sw_set: assert property (
		wr_set && host_req_in.wdata[0] |=> event_flags_out[0])
		else $error("set write lost");
	chk_hw_wins: assert property (
		wr_clr && events_in.lock_resp_err |=> event_flags_out[9])
		else $error("event lost to clear");
	chk_new_cycle: assert property (
		$past(rst_n_in) && $changed(cycle_count_lsb_in) |-> ##[1:2] event_flags_out[20])
		else $error("new cycle missed");
	chk_seconds_rollover: assert property (
		$past(rst_n_in) && $changed(cycle_seconds_in[6]) |-> ##[1:2] event_flags_out[21])
		else $error("rollover missed");
	// Main scenarios reached
	cover property (events_in.phy_bus_reset && events_in.self_id_stream_end);
	cover property (wr_clr && events_in.lock_resp_err);
	cover property (events_in.arb_reset_gap);
endmodule
bind serial_bus_interrupt_event_bits serial_bus_interrupt_event_bits_assertions i_chk (
	.mclk_in, .rst_n_in, .host_req_in, .rdata_out, .rvalid_out, .cycle_seconds_in,
	.cycle_count_lsb_in, .events_in, .int_mask_in, .event_flags_out);
`default_nettype wire

// ==== serial_bus_interrupt_event_bits_test.sv ====
`default_nettype none
module serial_bus_interrupt_event_bits_test;
	import irq_event_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	// ==========================================
	// Stimulus, observation and tallies
	logic			mclk_in = 0;
	logic			rst_n_in = 0;
	host_req_t		h = '0;
	hw_events_t		ev = '0;
	logic [6:0]		secs = '0;
	logic			lsb = 0;
	logic [22:0]	imask = '0;
	logic [7:0]		rx_ev = '0;
	logic [7:0]		rx_mk = '0;
	logic [7:0]		tx_ev = '0;
	logic [7:0]		tx_mk = '0;
	logic [31:0]	rdata;
	logic			rvalid;
	logic [22:0]	flags;
	int				n_errors = 0;
	int				tests_run = 0;
	int				cycles = 0;
	int				fb [14] = '{0, 0, 0, 0, 1, 2, 3, 4, 5, 16, 17, 19, 8, 9};
	serial_bus_interrupt_event_bits #(.ISO_CTX(8)) i_serial_bus_interrupt_event_bits (
		.mclk_in, .rst_n_in, .host_req_in(h), .rdata_out(rdata), .rvalid_out(rvalid),
		.cycle_seconds_in(secs), .cycle_count_lsb_in(lsb), .events_in(ev),
		.int_mask_in(imask), .iso_rx_event_in(rx_ev), .iso_rx_mask_in(rx_mk),
		.iso_tx_event_in(tx_ev), .iso_tx_mask_in(tx_mk), .event_flags_out(flags));
	// ==========================================
	// Clock, timeout and shared tasks
	initial
	begin
		forever #2 mclk_in = ~mclk_in;
	end
	always @(posedge mclk_in)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			n_errors++;
			final_report();
		end
	end
	task automatic final_report();
		if (n_errors == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic step(input int n = 1);
		repeat (n) @(posedge mclk_in);
		#1;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("Error %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic chf(input logic [22:0] e);
		chk({9'h0, flags}, {9'h0, e});
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		h = '{1'b1, 1'b0, a, d};
		step();
		h = '0;
		step();
	endtask
	task automatic clr();
		wr(OFS_EVENT_CLR, 32'hFFFFFFFF);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		h = '{1'b0, 1'b1, a, 32'h0};
		step();
		h = '0;
		chk({31'h0, rvalid}, 32'h1);
		chk(rdata, e);
		step();
	endtask
	task automatic fire(input logic [13:0] e);
		ev = hw_events_t'(e);
		step();
		ev = '0;
		step();
	endtask
	// ==========================================
	// Main sequence
	initial
	begin
		step(8);
		rst_n_in = 1;
		step();
		rd(OFS_EVENT_SET, 32'h0);
		for (int i = 3; i < 14; i++)
		begin
			fire(14'h1 << i);
			chf(23'h1 << fb[i]);
			clr();
			chf(23'h0);
		end
		fire(14'h200);
		fire(14'h600);
		chf(23'h020000);
		imask = 23'h0F0F0F;
		rx_ev = 8'h10;
		rx_mk = 8'h10;
		tx_ev = 8'h03;
		tx_mk = 8'h04;
		wr(OFS_EVENT_SET, 32'hFFFFFFFF);
		wr(OFS_EVENT_CLR, 32'h0);
		chf(LATCH_MASK);
		rd(OFS_EVENT_SET, {9'h0, LATCH_MASK | 23'h80});
		rd(OFS_EVENT_CLR, {9'h0, LATCH_MASK & 23'h0F0F0F});
		tx_mk = 8'h02;
		rd(OFS_EVENT_SET, {9'h0, LATCH_MASK | 23'hC0});
		wr(8'h8C, 32'hFFFFFFFF);
		rd(8'h8C, 32'h0);
		chf(LATCH_MASK);
		h = '{1'b1, 1'b0, OFS_EVENT_CLR, 32'hFFFFFFFF};
		ev.lock_resp_err = 1'b1;
		step();
		h = '0;
		ev = '0;
		step();
		chf(23'h000200);
		clr();
		lsb = 1;
		step(2);
		chf(23'h100000);
		fire(14'h1);
		lsb = 0;
		step(2);
		chf(23'h100000);
		lsb = 1;
		step(2);
		chf(23'h500000);
		clr();
		fire(14'h1);
		lsb = 0;
		step(2);
		chf(23'h100000);
		fire(14'h2);
		chf(23'h500000);
		clr();
		lsb = 1;
		step(2);
		fire(14'h4);
		chf(23'h100000);
		fire(14'h4);
		chf(23'h500000);
		clr();
		secs = 7'h40;
		step(2);
		chf(23'h200000);
		clr();
		secs = 7'h00;
		step(2);
		chf(23'h200000);
		final_report();
	end
endmodule
`default_nettype wire
